// ===== hdl/rsa_status.v
// Purpose: Rate select/indicate, carrier gating, lock and ancillary flag
// Assumes: i_clk is the parallel clock; core strobes are on that clock
// Notes: Pins pass a two-flop synchroniser before use
// Summary of operation
// R1: HD rate: ancillary flag follows chroma-stream ancillary detection.
// R2: SD rate, 20-bit width: flag follows chroma-stream ancillary detection only.
// R3: 10-bit width: flag follows ancillary detection anywhere in the stream.
// R4: Rate signal is an input in slave role, driven output in master.
// R5: Master role: drive rate low for HD or HD/1.001 streams.
// R6: Master role: drive rate high for SD streams.
// R7: Slave role, rate low: lock only to HD rate streams.
// R8: Slave role, rate high: lock only to SD rate streams.
// R9: Slave role: application resets device after setting or changing rate.
// R10: Serial input is valid while its carrier detect is low.
// R11: Selected carrier detect high: input invalid, lock indicator forced low.
// R12: Invalid selected input mutes every parallel output.
// R13: Role select high means master, low means slave.
// R14: Input select high picks first input and carrier; low picks second.
// R15: Lock indicator high only while locked to a compliant stream.
// R16: Chroma ancillary flag updates on the parallel clock with its data.
//
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
`include "rsa_regs.vh"

module rsa_status (
    input wire i_clk,
    input wire i_reset,
    // Pins from the board
    input wire i_role_master,
    input wire i_input_select,
    input wire i_carrier_detect_first,
    input wire i_carrier_detect_second,
    input wire i_bus_width_select,
    input wire i_rate_select,
    output wire o_rate_select,
    output wire o_rate_select_oe_n,
    // From the receive core, parallel clock domain
    input wire i_core_locked,
    input wire i_rate_det_valid,
    input wire i_rate_det_sd,
    input wire i_anc_chroma,
    input wire i_anc_luma,
    input wire [`RSA_VID_W-1:0] i_data,
    input wire i_data_valid,
    // To the receive core
    output wire o_rate_cfg_sd,
    output wire o_use_first_input,
    // Parallel output bus
    output wire [`RSA_VID_W-1:0] o_data,
    output wire o_data_valid,
    output wire o_chroma_anc_flag,
    output wire o_locked,
    // Register port
    input wire [`RSA_ADDR_W-1:0] i_addr,
    input wire [`RSA_DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [`RSA_DATA_W-1:0] o_rdata,
    output wire o_irq
);

wire [`RSA_PIN_W-1:0] pins_s;
wire master_s;
wire insel_s;
wire cd1_s;
wire cd2_s;
wire width20_s;
wire rate_pin_s;

rsa_sync2 #(
    .W(`RSA_PIN_W)
) u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_async({i_rate_select, i_bus_width_select, i_carrier_detect_second,
        i_carrier_detect_first, i_input_select, i_role_master}),
    .o_sync(pins_s)
);

assign master_s = pins_s[`RSA_PIN_MASTER]; // R13
assign insel_s = pins_s[`RSA_PIN_INSEL];
assign cd1_s = pins_s[`RSA_PIN_CD1];
assign cd2_s = pins_s[`RSA_PIN_CD2];
assign width20_s = pins_s[`RSA_PIN_WIDTH20];
assign rate_pin_s = pins_s[`RSA_PIN_RATE];

// Carrier selection and validity
wire cd_sel;
wire input_valid;

assign cd_sel = insel_s ? cd1_s : cd2_s; // R14
assign input_valid = ~cd_sel; // R10
assign o_use_first_input = insel_s; // R14

// Rate indication in master role
reg rate_out_r;
reg rate_out_nxt;

always @*
begin
    rate_out_nxt = rate_out_r;
    if (master_s && i_rate_det_valid)
    begin
        if (i_rate_det_sd)
            rate_out_nxt = 1'b1; // R6
        else
            rate_out_nxt = 1'b0; // R5
    end
end

always @(posedge i_clk)
begin
    if (i_reset)
        rate_out_r <= `RSA_RST_RATE_OUT;
    else
        rate_out_r <= rate_out_nxt;
end

// Pin drives only in master role; slave role leaves it to the application
assign o_rate_select = rate_out_r; // R4
assign o_rate_select_oe_n = ~master_s; // R4

// Rate the receiver works at
wire rate_eff_sd;

assign rate_eff_sd = master_s ? rate_out_r : rate_pin_s; // R4

// Slave role hard-locks the receiver to the configured rate
assign o_rate_cfg_sd = rate_pin_s; // R7 R8

// Lock qualification
wire rate_ok;
reg locked_r;
reg locked_nxt;

// Mismatched rate in slave role never counts as a lock
assign rate_ok = master_s |
    (i_rate_det_valid & (i_rate_det_sd == rate_pin_s)); // R7 R8

always @*
begin
    locked_nxt = i_core_locked & rate_ok; // R15
    if (!input_valid)
        locked_nxt = 1'b0; // R11
end

always @(posedge i_clk)
begin
    if (i_reset)
        locked_r <= 1'b0;
    else
        locked_r <= locked_nxt;
end

assign o_locked = locked_r;

// Parallel output muting
reg [`RSA_CTRL_W-1:0] ctrl_r;
wire mute;
reg [`RSA_VID_W-1:0] data_r;
reg data_valid_r;

assign mute = ~input_valid | ctrl_r[`RSA_CTRL_FORCE_MUTE]; // R12

always @(posedge i_clk)
begin
    if (i_reset)
    begin
        data_r <= {`RSA_VID_W{1'b0}};
        data_valid_r <= 1'b0;
    end
    else if (mute)
    begin
        data_r <= {`RSA_VID_W{1'b0}}; // R12
        data_valid_r <= 1'b0; // R12
    end
    else
    begin
        data_r <= i_data;
        data_valid_r <= i_data_valid;
    end
end

assign o_data = data_r;
assign o_data_valid = data_valid_r;

// Ancillary flag stays in step with data_r
rsa_anc_flag u_anc (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_rate_sd(rate_eff_sd),
    .i_width20(width20_s),
    .i_anc_chroma(i_anc_chroma),
    .i_anc_luma(i_anc_luma),
    .i_mute(mute),
    .o_chroma_anc_flag(o_chroma_anc_flag)
);

// Event detection
reg locked_d_r;
reg valid_d_r;
reg rate_d_r;
reg anc_d_r;
wire [`RSA_IRQ_W-1:0] events;
reg [1:0] settle_r;
wire settled;

// Synchroniser clears on reset, pulled-up rate pin would look like a change
always @(posedge i_clk)
begin
    if (i_reset)
        settle_r <= 2'h0;
    else if (!settled)
        settle_r <= settle_r + 2'h1;
end

assign settled = (settle_r == `RSA_SYNC_SETTLE);

always @(posedge i_clk)
begin
    if (i_reset)
    begin
        locked_d_r <= 1'b0;
        valid_d_r <= 1'b1;
        rate_d_r <= `RSA_RST_RATE_OUT;
        anc_d_r <= 1'b0;
    end
    else
    begin
        locked_d_r <= locked_r;
        valid_d_r <= input_valid;
        rate_d_r <= rate_eff_sd;
        anc_d_r <= o_chroma_anc_flag;
    end
end

// A rate change in slave role is the cue for the application to reset
assign events[`RSA_IRQ_LOCK_GAINED] = locked_r & ~locked_d_r;
assign events[`RSA_IRQ_LOCK_LOST] = ~locked_r & locked_d_r;
assign events[`RSA_IRQ_CD_INVALID] = ~input_valid & valid_d_r;
assign events[`RSA_IRQ_RATE_CHANGE] = (rate_eff_sd ^ rate_d_r) & settled; // R9
assign events[`RSA_IRQ_ANC_START] = o_chroma_anc_flag & ~anc_d_r;

// Register port
reg [`RSA_IRQ_W-1:0] irq_st_r;
reg [`RSA_IRQ_W-1:0] irq_st_nxt;
reg [`RSA_IRQ_W-1:0] irq_mask_r;
reg [`RSA_DATA_W-1:0] rdata_r;
reg [`RSA_DATA_W-1:0] rdata_nxt;
wire [`RSA_ST_W-1:0] status;

function hit;
    input [`RSA_ADDR_W-1:0] addr;
    input [`RSA_ADDR_W-1:0] off;
    begin
        hit = (addr == off);
    end
endfunction

assign status = {o_chroma_anc_flag, width20_s, insel_s, master_s,
    rate_eff_sd, ~input_valid, locked_r};

always @*
begin
    irq_st_nxt = irq_st_r;
    if (i_rd && hit(i_addr, `RSA_OFF_IRQ_STATUS))
        irq_st_nxt = {`RSA_IRQ_W{1'b0}};
    // Set wins over a clear in the same cycle
    irq_st_nxt = irq_st_nxt | events;
end

always @*
begin
    rdata_nxt = {`RSA_DATA_W{1'b0}};
    if (i_rd)
    begin
        case (i_addr)
            `RSA_OFF_STATUS:
                rdata_nxt[`RSA_ST_W-1:0] = status;
            `RSA_OFF_IRQ_STATUS:
                rdata_nxt[`RSA_IRQ_W-1:0] = irq_st_r;
            `RSA_OFF_IRQ_MASK:
                rdata_nxt[`RSA_IRQ_W-1:0] = irq_mask_r;
            `RSA_OFF_CTRL:
                rdata_nxt[`RSA_CTRL_W-1:0] = ctrl_r;
            default:
                rdata_nxt = {`RSA_DATA_W{1'b0}};
        endcase
    end
end

always @(posedge i_clk)
begin
    if (i_reset)
    begin
        irq_st_r <= {`RSA_IRQ_W{1'b0}};
        irq_mask_r <= `RSA_RST_IRQ_MASK;
        ctrl_r <= `RSA_RST_CTRL;
        rdata_r <= {`RSA_DATA_W{1'b0}};
    end
    else
    begin
        irq_st_r <= irq_st_nxt;
        rdata_r <= rdata_nxt;
        if (i_wr && hit(i_addr, `RSA_OFF_IRQ_MASK))
            irq_mask_r <= i_wdata[`RSA_IRQ_W-1:0];
        if (i_wr && hit(i_addr, `RSA_OFF_CTRL))
            ctrl_r <= i_wdata[`RSA_CTRL_W-1:0];
    end
end

assign o_rdata = rdata_r;
assign o_irq = |(irq_st_r & irq_mask_r);

endmodule // rsa_status

`default_nettype wire

// ===== hdl/rsa_regs.vh
// Purpose: Constants for the rate select, ancillary flag and status block
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes: Definitions only
`ifndef RSA_REGS_VH
`define RSA_REGS_VH

`define RSA_ADDR_W 4
`define RSA_DATA_W 32
`define RSA_VID_W 20
`define RSA_PIN_W 6

// Register byte offsets
`define RSA_OFF_STATUS 4'h0
`define RSA_OFF_IRQ_STATUS 4'h4
`define RSA_OFF_IRQ_MASK 4'h8
`define RSA_OFF_CTRL 4'hc

// Status register fields
`define RSA_ST_LOCKED 0
`define RSA_ST_CD_INVALID 1
`define RSA_ST_RATE_SD 2
`define RSA_ST_MASTER 3
`define RSA_ST_INPUT_FIRST 4
`define RSA_ST_WIDTH20 5
`define RSA_ST_CHROMA_ANC 6
`define RSA_ST_W 7

// Interrupt status and mask fields
`define RSA_IRQ_LOCK_GAINED 0
`define RSA_IRQ_LOCK_LOST 1
`define RSA_IRQ_CD_INVALID 2
`define RSA_IRQ_RATE_CHANGE 3
`define RSA_IRQ_ANC_START 4
`define RSA_IRQ_W 5

// Control register fields
`define RSA_CTRL_FORCE_MUTE 0
`define RSA_CTRL_W 1

// Synchronised pin vector positions
`define RSA_PIN_MASTER 0
`define RSA_PIN_INSEL 1
`define RSA_PIN_CD1 2
`define RSA_PIN_CD2 3
`define RSA_PIN_WIDTH20 4
`define RSA_PIN_RATE 5

// Reset values
`define RSA_RST_IRQ_MASK 5'h00
`define RSA_RST_CTRL 1'h0
`define RSA_RST_RATE_OUT 1'h1

// Cycles after reset before the synchronised rate pin is trusted for rate change events
`define RSA_SYNC_SETTLE 2'h3

`endif

// ===== hdl/rsa_sync2.v
// Purpose: Two-flop synchroniser for a vector of unrelated pin levels
// Assumes: Each bit is an independent level, no word coherence needed
// Notes: First stage is read by the second stage only
`default_nettype none

module rsa_sync2 #(
    parameter W = 6
) (
    input wire i_clk,
    input wire i_reset,
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

reg [W-1:0] meta_r;
reg [W-1:0] sync_r;

always @(posedge i_clk)
begin
    if (i_reset)
    begin
        meta_r <= {W{1'b0}};
        sync_r <= {W{1'b0}};
    end
    else
    begin
        meta_r <= i_async;
        sync_r <= meta_r;
    end
end

assign o_sync = sync_r;

endmodule // rsa_sync2

`default_nettype wire

// ===== hdl/rsa_anc_flag.v
// Purpose: Chroma ancillary-data flag per rate and output bus width
// Assumes: Detection strobes arrive aligned with the word being output
// Notes: Registered so it lines up with the registered parallel data
`default_nettype none

module rsa_anc_flag (
    input wire i_clk,
    input wire i_reset,
    input wire i_rate_sd,
    input wire i_width20,
    input wire i_anc_chroma,
    input wire i_anc_luma,
    input wire i_mute,
    output wire o_chroma_anc_flag
);

reg flag_r;
reg flag_nxt;

always @*
begin
    if (!i_width20)
        flag_nxt = i_anc_chroma | i_anc_luma; // R3
    else if (i_rate_sd)
        flag_nxt = i_anc_chroma; // R2
    else
        flag_nxt = i_anc_chroma; // R1
    if (i_mute)
        flag_nxt = 1'b0; // R12
end

always @(posedge i_clk)
begin
    if (i_reset)
        flag_r <= 1'b0;
    else
        flag_r <= flag_nxt; // R16
end

assign o_chroma_anc_flag = flag_r;

endmodule // rsa_anc_flag

`default_nettype wire

// ===== verif/rsa_app_model.sv
// Purpose: Application side of the two-way rate pin, with its pull-up
// Assumes: Device drive enable is active low
// Notes: Pin floats high when nobody drives it
`default_nettype none

module rsa_app_model (
    input wire logic i_app_en,
    input wire logic i_app_level,
    input wire logic i_dev_oe_n,
    input wire logic i_dev_level,
    output logic o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device wins in master role; the app drives only in slave role
    assign o_pin = !i_dev_oe_n ? i_dev_level : (i_app_en ? i_app_level : 1'b1);
endmodule // rsa_app_model

`default_nettype wire

// ===== verif/rsa_props.sv
// Purpose: Port-level checks of the status block
// Assumes: Pins reach the logic after two synchroniser flops
// Notes: Six of the ten checks are held off until the synchronisers have refilled
`default_nettype none
`include "rsa_regs.vh"

module rsa_props (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_role_master,
    input wire logic i_carrier_detect_first,
    input wire logic i_carrier_detect_second,
    input wire logic i_bus_width_select,
    input wire logic i_core_locked,
    input wire logic i_rate_det_valid,
    input wire logic i_rate_det_sd,
    input wire logic i_anc_chroma,
    input wire logic i_anc_luma,
    input wire logic [`RSA_VID_W-1:0] i_data,
    input wire logic o_rate_select,
    input wire logic o_rate_select_oe_n,
    input wire logic o_rate_cfg_sd,
    input wire logic o_use_first_input,
    input wire logic [`RSA_VID_W-1:0] o_data,
    input wire logic o_data_valid,
    input wire logic o_chroma_anc_flag,
    input wire logic o_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] up_r;
    logic [1:0] q1_r;
    logic [1:0] q2_r;
    wire logic up = (up_r == 2'h3);
    wire logic bad = o_use_first_input ? q1_r[1] : q2_r[1];
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    always_ff @(posedge i_clk)
    begin
        up_r <= i_reset ? 2'h0 : (up ? up_r : up_r + 2'h1);
        q1_r <= {q1_r[0], i_carrier_detect_first};
        q2_r <= {q2_r[0], i_carrier_detect_second};
    end
    lock_cd_a: assert property (up && bad |=> !o_locked)
        else $error("lock high with invalid carrier");
    mute_out_a: assert property (up && bad
        |=> o_data == 0 && !o_data_valid && !o_chroma_anc_flag)
        else $error("outputs not muted");
    flag_narrow_a: assert property (up && o_data_valid && !$past(i_bus_width_select, 3)
        |-> o_chroma_anc_flag == $past(i_anc_chroma | i_anc_luma))
        else $error("narrow flag wrong");
    flag_wide_a: assert property (up && o_data_valid && $past(i_bus_width_select, 3)
        |-> o_chroma_anc_flag == $past(i_anc_chroma))
        else $error("wide flag wrong");
    data_pass_a: assert property (o_data_valid |-> o_data == $past(i_data))
        else $error("data not aligned");
    oe_role_a: assert property (up |-> o_rate_select_oe_n == !$past(i_role_master, 2))
        else $error("rate drive enable wrong");
    rate_drive_a: assert property (!o_rate_select_oe_n && i_rate_det_valid
        |=> o_rate_select == $past(i_rate_det_sd))
        else $error("rate indication wrong");
    lock_rate_a: assert property (o_rate_select_oe_n && i_rate_det_sd != o_rate_cfg_sd
        |=> !o_locked)
        else $error("locked to wrong rate");
    lock_master_a: assert property (up && !bad && !o_rate_select_oe_n && i_core_locked
        |=> o_locked)
        else $error("lock missing on valid input");
    lock_core_a: assert property (o_locked |-> $past(i_core_locked))
        else $error("lock without core lock");
    cover property (up && bad ##1 !o_locked);
    cover property (o_data_valid && o_chroma_anc_flag);
    cover property (!o_rate_select_oe_n && o_locked);
endmodule // rsa_props

bind rsa_status rsa_props u_props (.*);

`default_nettype wire

// ===== verif/tb_rate_select_anc_flag_status.sv
// Purpose: Directed bench for the status block
// Assumes: Pins settle in four cycles
// Notes: Reset pulses follow rate pin changes in slave role
`default_nettype none

module tb_rate_select_anc_flag_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_reset = 1, role = 0, insel = 1, cd1 = 0, cd2 = 0, wide = 0;
    logic core_lk = 0, dv = 0, dsd = 0, ach = 0, alu = 0, din_v = 0, wr = 0, rd = 0;
    logic app_en = 1, app_lv = 1;
    logic [19:0] din = 0;
    logic [3:0] addr = 0;
    logic [31:0] wdata = 0, d;
    wire logic rate_pin, rate_o, oe_n, cfg, use1, dout_v, flag, lk, irq;
    wire logic [19:0] dout;
    wire logic [31:0] rdata;
    int fail_count = 0, samples_checked = 0, cyc = 0;
    always #5 i_clk = ~i_clk;
    rsa_app_model u_app (.i_app_en(app_en), .i_app_level(app_lv), .i_dev_oe_n(oe_n),
        .i_dev_level(rate_o), .o_pin(rate_pin));
    rsa_status u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_role_master(role),
        .i_input_select(insel), .i_carrier_detect_first(cd1), .i_carrier_detect_second(cd2),
        .i_bus_width_select(wide), .i_rate_select(rate_pin), .o_rate_select(rate_o),
        .o_rate_select_oe_n(oe_n), .i_core_locked(core_lk), .i_rate_det_valid(dv),
        .i_rate_det_sd(dsd), .i_anc_chroma(ach), .i_anc_luma(alu), .i_data(din),
        .i_data_valid(din_v), .o_rate_cfg_sd(cfg), .o_use_first_input(use1), .o_data(dout),
        .o_data_valid(dout_v), .o_chroma_anc_flag(flag), .o_locked(lk), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
    task automatic final_report;
        $display("checks %0d errors %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask
    task automatic wrt(input logic [3:0] a, input logic [31:0] v);
        @(posedge i_clk) {addr, wdata, wr} <= {a, v, 1'b1};
        @(posedge i_clk) wr <= 0;
        #1;
    endtask
    task automatic rdd(input logic [3:0] a, output logic [31:0] v);
        @(posedge i_clk) {addr, rd} <= {a, 1'b1};
        @(posedge i_clk) rd <= 0;
        #1 v = rdata;
    endtask
    task automatic p(input logic r, s, c1, c2, w, ae, al);
        @(posedge i_clk) {role, insel, cd1, cd2, wide, app_en, app_lv}
            <= {r, s, c1, c2, w, ae, al};
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    task automatic r9;
        @(posedge i_clk) i_reset <= 1;
        repeat (2) @(posedge i_clk);
        i_reset <= 0;
        repeat (3) @(posedge i_clk);
        #1;
    endtask
    task automatic vid(input logic c, l);
        @(posedge i_clk) {ach, alu, din, din_v} <= {c, l, 20'h5a5a5, 1'b1};
        @(posedge i_clk);
        #1;
    endtask
    task automatic lkc(input logic sd, e);
        @(posedge i_clk) {core_lk, dv, dsd} <= {2'h3, sd};
        repeat (2) @(posedge i_clk);
        #1 chk("locked", e, lk);
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        // Whole run needs well under a thousand cycles
        if (cyc == 5000)
        begin
            fail_count++;
            final_report;
        end
    end
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_reset <= 0;
        #1 chk("rate_rst", 1, rate_o);
        rdd(4'h8, d); chk("mask_rst", 0, d);
        rdd(4'h1, d); chk("unmapped", 0, d);
        rdd(4'h4, d); chk("irq_rst", 0, d);
        p(0, 1, 0, 0, 0, 1, 1); vid(0, 1); chk("flag", 1, flag);
        chk("data", 20'h5a5a5, dout);
        p(0, 1, 0, 0, 1, 1, 1); r9; vid(0, 1); chk("flag", 0, flag);
        vid(1, 0); chk("flag", 1, flag);
        p(0, 1, 0, 0, 1, 1, 0); rdd(4'h4, d); chk("rate_change", 1, d[3]);
        r9; vid(1, 1); chk("flag", 1, flag);
        vid(0, 1); chk("flag", 0, flag);
        lkc(0, 1);
        lkc(1, 0);
        p(0, 1, 0, 1, 1, 1, 1); r9; lkc(1, 1);
        lkc(0, 0);
        lkc(1, 1); p(0, 1, 1, 1, 1, 1, 1); chk("locked", 0, lk);
        vid(1, 0); chk("mute", 0, {dout_v, flag, dout});
        p(0, 0, 1, 0, 1, 1, 1); chk("use_first", 0, use1);
        chk("locked", 1, lk);
        wrt(4'hc, 32'h1); rdd(4'hc, d); chk("ctrl", 1, d);
        vid(1, 0); chk("force_mute", 0, {dout_v, flag, dout});
        wrt(4'hc, 32'h0); vid(1, 0); chk("unmuted", 20'h5a5a5, dout);
        p(1, 0, 1, 0, 1, 0, 1); chk("oe_n", 0, oe_n);
        lkc(0, 1); chk("rate", 0, {rate_o, rate_pin});
        lkc(1, 1); chk("rate", 3, {rate_o, rate_pin});
        wrt(4'h8, 32'h2);
        rdd(4'h4, d); chk("irq_clear", 0, irq);
        @(posedge i_clk) cd2 <= 1;
        repeat (4) @(posedge i_clk);
        #1 chk("irq", 1, irq);
        wrt(4'h8, 32'h0); chk("irq_masked", 0, irq);
        wrt(4'h8, 32'h2); chk("irq", 1, irq);
        rdd(4'h0, d); chk("status", 32'h2e, d);
        rdd(4'h4, d); chk("lock_lost", 1, d[1]);
        chk("irq_status", 32'h6, d);
        chk("irq_cleared", 0, irq);
        final_report;
    end
endmodule // tb_rate_select_anc_flag_status

`default_nettype wire
